// file: gpx_pkg.sv
package gpx_pkg;

	// ****************************************************************
	// bus geometry
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// ****************************************************************
	// register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFF_LATCH4 = 8'h00;
	localparam logic [7:0] OFF_LATCH5 = 8'h04;
	localparam logic [7:0] OFF_LATCH6 = 8'h08;
	localparam logic [7:0] OFF_LATCH7 = 8'h0C;
	localparam logic [7:0] OFF_LATCH12 = 8'h10;
	localparam logic [7:0] OFF_LATCH13 = 8'h14;
	localparam logic [7:0] OFF_DIR5 = 8'h20;
	localparam logic [7:0] OFF_DIR6 = 8'h24;
	localparam logic [7:0] OFF_DIR7 = 8'h28;
	localparam logic [7:0] OFF_DIR12 = 8'h2C;
	localparam logic [7:0] OFF_DIR13 = 8'h30;
	localparam logic [7:0] OFF_PULLUP_OPTION_LOW_REG = 8'h40;
	localparam logic [7:0] OFF_PULLUP_OPTION_HIGH_REG = 8'h44;
	localparam logic [7:0] OFF_MEMEXP = 8'h48;
	localparam logic [7:0] OFF_KRMODE = 8'h4C;
	localparam logic [7:0] OFF_KRFLAG = 8'h50;

	// ****************************************************************
	// reset values and writable masks
	// ****************************************************************
	localparam logic [7:0] DIR_RESET = 8'hFF;
	localparam logic [7:0] PUO_RESET = 8'h00;
	localparam logic [7:0] MEMEXP_RESET = 8'h10;
	localparam logic [7:0] KRMODE_RESET = 8'h00;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [7:0] MEMEXP_WMASK = 8'h37;
	localparam logic [7:0] PULLUP_OPTION_LOW_REG_WMASK = 8'hF0;
	localparam logic [7:0] PULLUP_OPTION_HIGH_REG_WMASK = 8'h30;
	localparam logic [7:0] KRMODE_WMASK = 8'h01;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int PULLUP_OPTION_LOW_REG_P4_BIT = 4;
	localparam int PULLUP_OPTION_LOW_REG_P5_BIT = 5;
	localparam int PULLUP_OPTION_LOW_REG_P6U_BIT = 6;
	localparam int PULLUP_OPTION_LOW_REG_P7_BIT = 7;
	localparam int PULLUP_OPTION_HIGH_REG_P12_BIT = 4;
	localparam int PULLUP_OPTION_HIGH_REG_P13_BIT = 5;
	localparam int MEMEXP_MODE_LSB = 0;
	localparam int MEMEXP_WAIT_LSB = 4;
	localparam int KRMODE_OFF_BIT = 0;
	localparam int KRFLAG_BIT = 0;
	localparam int WAIT_PIN_BIT = 6;

	// ****************************************************************
	// expansion mode codes
	// ****************************************************************
	localparam logic [2:0] MODE_P4_IN = 3'h0;
	localparam logic [2:0] MODE_P4_OUT = 3'h1;
	localparam logic [2:0] MODE_EXP_256 = 3'h3;
	localparam logic [2:0] MODE_EXP_4K = 3'h4;
	localparam logic [2:0] MODE_EXP_16K = 3'h5;
	localparam logic [7:0] P5_ALT_4K = 8'h0F;
	localparam logic [7:0] P5_ALT_16K = 8'h3F;

	// ****************************************************************
	// bus responses
	// ****************************************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: gpx_key_if.sv
// carries the key return edge detector's pins, control and flag
interface gpx_key_if;
	logic [7:0] pins;
	logic detect_off;
	logic clear;
	logic flag;

	// ****************************************************************
	// detector side and control side
	// ****************************************************************
	modport det (input pins, input detect_off, input clear, output flag);
	modport ctl (output pins, output detect_off, output clear, input flag);
endinterface

// file: gpx_keydet.sv
module gpx_keydet (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// detector carrier
	gpx_key_if.det key
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] prev;
		logic flag;
	} gpx_kd_state_type;

	gpx_kd_state_type st;
	gpx_kd_state_type next_st;
	logic fall;

	// sync1 feeds only sync2; edges are judged on the settled stages
	always_comb begin
		next_st = st;
		next_st.sync1 = key.pins;
		next_st.sync2 = st.sync1;
		next_st.prev = st.sync2;
		fall = (|(st.prev & ~st.sync2)) & ~key.detect_off;
		// a new edge in the clear cycle wins over the clear
		if (fall) begin
			next_st.flag = 1'b1;
		end else if (key.clear) begin
			next_st.flag = 1'b0;
		end
	end

	// prev and syncs start high, so a pin already low after reset counts as a falling edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '{sync1: 8'hFF, sync2: 8'hFF, prev: 8'hFF, flag: 1'b0};
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign key.flag = st.flag;
endmodule // gpx_keydet

// file: gpx_gpio.sv
// Notes on behaviour
// - port 4 direction is one byte-wide setting from the memory expansion mode register.
// - port 4 inputs share one pull-up enable in the low pull-up register.
// - a falling edge on any port 4 pin sets the key return test flag.
// - after reset ports 4, 5, 6, 7, 12 and 13 are all inputs.
// - each port 5 pin has its own direction bit.
// - port 5 inputs share one pull-up enable in the low pull-up register.
// - each port 6 pin has its own direction bit.
// - the upper four port 6 pins share one pull-up enable.
// - that upper port 6 pull-up enable is bit 6 of the low register.
// - lower port 6 pull-ups are fixed per pin at build, never software.
// - in expansion mode without wait, the wait pin stays an ordinary port pin.
// - port 7 has three pins, per-pin direction, one shared pull-up enable.
// - port 12 has per-pin direction, one high-register pull-up enable.
// - both port 13 pins share one high-register pull-up enable.
// - each port 13 pin has its own direction bit.
// - direction, two pull-up, expansion mode and key return mode registers steer ports.
// - expansion mode gives port 4 and port 6 pins 7, 5 and 4 (pin 6 only with wait) to the bus, and port 5 pins too in the 4K and 16K modes.
// - all direction registers reset to all ones, that is input.
// - pull-ups act only on pins in input mode, never outputs or alternates.
// - both pull-up registers reset to zero.
// - the expansion mode register resets to port 4 input, no expansion.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
module gpx_gpio
	import gpx_pkg::*;
#(
	parameter logic [3:0] P6_LOW_PULLUP = 4'h0
) (
	// clock, reset, enable
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic CE,
	// axi4-lite write address and data
	input wire logic [gpx_pkg::ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [gpx_pkg::DATA_W-1:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	// axi4-lite write response
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// axi4-lite read
	input wire logic [gpx_pkg::ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [gpx_pkg::DATA_W-1:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// port 4 pins
	input wire logic [7:0] P4_IN,
	output logic [7:0] P4_OUT,
	output logic [7:0] P4_OE,
	output logic [7:0] P4_PU,
	// port 5 pins
	input wire logic [7:0] P5_IN,
	output logic [7:0] P5_OUT,
	output logic [7:0] P5_OE,
	output logic [7:0] P5_PU,
	// port 6 pins
	input wire logic [7:0] P6_IN,
	output logic [7:0] P6_OUT,
	output logic [7:0] P6_OE,
	output logic [7:0] P6_PU,
	// port 7 pins
	input wire logic [2:0] P7_IN,
	output logic [2:0] P7_OUT,
	output logic [2:0] P7_OE,
	output logic [2:0] P7_PU,
	// port 12 pins
	input wire logic [7:0] P12_IN,
	output logic [7:0] P12_OUT,
	output logic [7:0] P12_OE,
	output logic [7:0] P12_PU,
	// port 13 pins
	input wire logic [1:0] P13_IN,
	output logic [1:0] P13_OUT,
	output logic [1:0] P13_OE,
	output logic [1:0] P13_PU,
	// external bus controller side
	input wire logic [7:0] BUS_AD_OUT,
	input wire logic BUS_AD_OE,
	output logic [7:0] BUS_AD_IN,
	input wire logic [7:0] BUS_ADDR_HI,
	input wire logic BUS_RD_N,
	input wire logic BUS_WR_N,
	input wire logic BUS_ASTB,
	output logic BUS_WAIT_N,
	output logic BUS_EXP_ON,
	// key return test flag level
	output logic KEY_FLAG
);
	import gpx_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic aw_hold;
		logic [7:0] aw_addr;
		logic w_hold;
		logic [31:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] latch4;
		logic [7:0] latch5;
		logic [7:0] latch6;
		logic [2:0] latch7;
		logic [7:0] latch12;
		logic [1:0] latch13;
		logic [7:0] dir5;
		logic [7:0] dir6;
		logic [2:0] dir7;
		logic [7:0] dir12;
		logic [1:0] dir13;
		logic [7:0] pullup_option_low_reg;
		logic [7:0] pullup_option_high_reg;
		logic [7:0] memexp;
		logic [7:0] krmode;
	} gpx_state_type;

	gpx_state_type st;
	gpx_state_type next_st;
	gpx_key_if key ();

	logic [2:0] mode;
	logic exp_on;
	logic p4_out_mode;
	logic wait_used;
	logic [7:0] p5_alt;
	logic [7:0] p6_alt;
	logic [7:0] p6_alt_drive;
	logic [7:0] p6_alt_val;
	logic do_write;
	logic [7:0] wbyte;
	logic [7:0] rd_byte;
	logic rd_hit;
	logic wr_hit;

	// pin value for inputs, latch value for outputs
	function automatic logic [7:0] mix(input logic [7:0] pin, input logic [7:0] lat,
		input logic [7:0] dir);
		mix = (pin & dir) | (lat & ~dir);
	endfunction

	// ****************************************************************
	// key return edge detector
	// ****************************************************************
	assign key.pins = P4_IN;
	assign key.detect_off = st.krmode[KRMODE_OFF_BIT];
	// a write without lane 0 must not clear the flag either
	assign key.clear = do_write && st.w_lane0 && st.aw_addr == OFF_KRFLAG && wbyte[KRFLAG_BIT];

	gpx_keydet u_keydet (
		.clk(REF_CLK),
		.rst_n(RESETN),
		.ce(CE),
		.key(key)
	);

	// ****************************************************************
	// mode decode
	// ****************************************************************
	// expansion codes take the pins; anything else leaves them as ports
	always_comb begin
		mode = st.memexp[MEMEXP_MODE_LSB +: 3];
		exp_on = mode == MODE_EXP_256 || mode == MODE_EXP_4K || mode == MODE_EXP_16K;
		p4_out_mode = mode == MODE_P4_OUT;
		wait_used = exp_on && (st.memexp[MEMEXP_WAIT_LSB +: 2] != 2'h0);
		case (mode)
			MODE_EXP_4K: p5_alt = P5_ALT_4K;
			MODE_EXP_16K: p5_alt = P5_ALT_16K;
			default: p5_alt = 8'h00;
		endcase
		// the wait pin joins the bus only when a wait is really used
		p6_alt_drive = exp_on ? 8'hB0 : 8'h00;
		p6_alt = p6_alt_drive | {1'b0, wait_used, 6'h00};
		p6_alt_val = {BUS_ASTB, 1'b1, BUS_WR_N, BUS_RD_N, 4'h0};
	end

	// ****************************************************************
	// pin drivers and pull-ups
	// ****************************************************************
	// port 4 turns as one byte, so all eight enables move together
	always_comb begin
		P4_OUT = exp_on ? BUS_AD_OUT : st.latch4;
		P4_OE = exp_on ? {8{BUS_AD_OE}} : {8{p4_out_mode}};
		P4_PU = {8{st.pullup_option_low_reg[PULLUP_OPTION_LOW_REG_P4_BIT] & ~exp_on & ~p4_out_mode}};
	end

	// port 5: per-pin direction, upper address pins in the 4K and 16K expansion modes
	always_comb begin
		P5_OUT = (BUS_ADDR_HI & p5_alt) | (st.latch5 & ~p5_alt);
		P5_OE = p5_alt | ~st.dir5;
		P5_PU = {8{st.pullup_option_low_reg[PULLUP_OPTION_LOW_REG_P5_BIT]}} & st.dir5 & ~p5_alt;
	end

	// port 6: upper nibble software pull-up, lower nibble built-in only
	always_comb begin
		P6_OUT = (p6_alt_val & p6_alt_drive) | (st.latch6 & ~p6_alt);
		P6_OE = p6_alt_drive | (~st.dir6 & ~p6_alt);
		P6_PU[7:4] = {4{st.pullup_option_low_reg[PULLUP_OPTION_LOW_REG_P6U_BIT]}} & st.dir6[7:4] & ~p6_alt[7:4];
		P6_PU[3:0] = P6_LOW_PULLUP & st.dir6[3:0];
		BUS_WAIT_N = wait_used ? P6_IN[WAIT_PIN_BIT] : 1'b1;
	end

	// ports 7, 12 and 13 have no bus role here
	always_comb begin
		P7_OUT = st.latch7;
		P7_OE = ~st.dir7;
		P7_PU = {3{st.pullup_option_low_reg[PULLUP_OPTION_LOW_REG_P7_BIT]}} & st.dir7;
		P12_OUT = st.latch12;
		P12_OE = ~st.dir12;
		P12_PU = {8{st.pullup_option_high_reg[PULLUP_OPTION_HIGH_REG_P12_BIT]}} & st.dir12;
		P13_OUT = st.latch13;
		P13_OE = ~st.dir13;
		P13_PU = {2{st.pullup_option_high_reg[PULLUP_OPTION_HIGH_REG_P13_BIT]}} & st.dir13;
	end

	assign BUS_AD_IN = P4_IN;
	assign BUS_EXP_ON = exp_on;
	assign KEY_FLAG = key.flag;

	// ****************************************************************
	// register read decode
	// ****************************************************************
	// unused upper direction bits read as one, like a parked input
	always_comb begin
		rd_hit = 1'b1;
		case (ARADDR)
			OFF_LATCH4: rd_byte = p4_out_mode ? st.latch4 : P4_IN;
			OFF_LATCH5: rd_byte = mix(P5_IN, st.latch5, st.dir5);
			OFF_LATCH6: rd_byte = mix(P6_IN, st.latch6, st.dir6);
			OFF_LATCH7: rd_byte = mix({5'h00, P7_IN}, {5'h00, st.latch7}, {5'h1F, st.dir7});
			OFF_LATCH12: rd_byte = mix(P12_IN, st.latch12, st.dir12);
			OFF_LATCH13: rd_byte = mix({6'h00, P13_IN}, {6'h00, st.latch13}, {6'h3F, st.dir13});
			OFF_DIR5: rd_byte = st.dir5;
			OFF_DIR6: rd_byte = st.dir6;
			OFF_DIR7: rd_byte = {5'h1F, st.dir7};
			OFF_DIR12: rd_byte = st.dir12;
			OFF_DIR13: rd_byte = {6'h3F, st.dir13};
			OFF_PULLUP_OPTION_LOW_REG: rd_byte = st.pullup_option_low_reg;
			OFF_PULLUP_OPTION_HIGH_REG: rd_byte = st.pullup_option_high_reg;
			OFF_MEMEXP: rd_byte = st.memexp;
			OFF_KRMODE: rd_byte = st.krmode;
			OFF_KRFLAG: rd_byte = {7'h00, key.flag};
			default: begin
				rd_byte = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// axi4-lite handshakes
	// ****************************************************************
	// one slot per channel; a held beat blocks the next until used
	assign AWREADY = ~st.aw_hold;
	assign WREADY = ~st.w_hold;
	assign ARREADY = ~st.rvalid;
	assign BVALID = st.bvalid;
	assign BRESP = st.bresp;
	assign RVALID = st.rvalid;
	assign RDATA = st.rdata;
	assign RRESP = st.rresp;
	assign do_write = st.aw_hold && st.w_hold && !st.bvalid;
	assign wbyte = st.w_data[7:0];

	always_comb begin
		case (st.aw_addr)
			OFF_LATCH4, OFF_LATCH5, OFF_LATCH6, OFF_LATCH7, OFF_LATCH12, OFF_LATCH13,
			OFF_DIR5, OFF_DIR6, OFF_DIR7, OFF_DIR12, OFF_DIR13, OFF_PULLUP_OPTION_LOW_REG, OFF_PULLUP_OPTION_HIGH_REG,
			OFF_MEMEXP, OFF_KRMODE, OFF_KRFLAG: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		next_st = st;
		// capture address and data in whichever order they come
		if (AWVALID && !st.aw_hold) begin
			next_st.aw_hold = 1'b1;
			next_st.aw_addr = AWADDR;
		end
		if (WVALID && !st.w_hold) begin
			next_st.w_hold = 1'b1;
			next_st.w_data = WDATA;
			next_st.w_lane0 = WSTRB[0];
		end
		if (st.bvalid && BREADY) begin
			next_st.bvalid = 1'b0;
		end
		// registers sit in lane 0; a write without that lane changes nothing
		if (do_write) begin
			next_st.aw_hold = 1'b0;
			next_st.w_hold = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
			if (st.w_lane0) begin
				case (st.aw_addr)
					OFF_LATCH4: next_st.latch4 = wbyte;
					OFF_LATCH5: next_st.latch5 = wbyte;
					OFF_LATCH6: next_st.latch6 = wbyte;
					OFF_LATCH7: next_st.latch7 = wbyte[2:0];
					OFF_LATCH12: next_st.latch12 = wbyte;
					OFF_LATCH13: next_st.latch13 = wbyte[1:0];
					OFF_DIR5: next_st.dir5 = wbyte;
					OFF_DIR6: next_st.dir6 = wbyte;
					OFF_DIR7: next_st.dir7 = wbyte[2:0];
					OFF_DIR12: next_st.dir12 = wbyte;
					OFF_DIR13: next_st.dir13 = wbyte[1:0];
					OFF_PULLUP_OPTION_LOW_REG: next_st.pullup_option_low_reg = wbyte & PULLUP_OPTION_LOW_REG_WMASK;
					OFF_PULLUP_OPTION_HIGH_REG: next_st.pullup_option_high_reg = wbyte & PULLUP_OPTION_HIGH_REG_WMASK;
					OFF_MEMEXP: next_st.memexp = wbyte & MEMEXP_WMASK;
					OFF_KRMODE: next_st.krmode = wbyte & KRMODE_WMASK;
					default: next_st.krmode = st.krmode;
				endcase
			end
		end
		// read answers one cycle after the address is taken
		if (st.rvalid && RREADY) begin
			next_st.rvalid = 1'b0;
		end
		if (ARVALID && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = {24'h00_0000, rd_byte};
			next_st.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	// reset leaves every pin undriven and every software pull-up off
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			st <= '0;
			st.dir5 <= DIR_RESET;
			st.dir6 <= DIR_RESET;
			st.dir7 <= DIR_RESET[2:0];
			st.dir12 <= DIR_RESET;
			st.dir13 <= DIR_RESET[1:0];
			st.pullup_option_low_reg <= PUO_RESET;
			st.pullup_option_high_reg <= PUO_RESET;
			st.memexp <= MEMEXP_RESET;
			st.krmode <= KRMODE_RESET;
			st.latch4 <= LATCH_RESET;
		end else if (CE) begin
			st <= next_st;
		end
	end
endmodule // gpx_gpio

// file: gpx_pin_model.sv
module gpx_pin_model #(
	parameter int W = 8
) (
	// clock
	input wire logic clk,
	// device side
	input wire logic [W-1:0] oe,
	input wire logic [W-1:0] out,
	input wire logic [W-1:0] pu,
	// external circuit
	input wire logic [W-1:0] ext,
	input wire logic [W-1:0] en,
	// resolved level
	output logic [W-1:0] pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [W-1:0] last;
	// a floating pin shows the inverse of its last level, never a stale value
	always_ff @(posedge clk) begin
		last <= pin;
	end
	// device drive wins, then the external source, then the pull-up
	always_comb begin
		pin = (oe & out) | (~oe & en & ext) | (~oe & ~en & (pu | ~last));
	end
endmodule // gpx_pin_model

// file: gpx_gpio_monitor.sv
module gpx_gpio_monitor
	import gpx_pkg::*;
#(
	parameter logic [3:0] P6_LOW_PULLUP = 4'h0
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RESETN,
	// bus
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic RVALID,
	input wire logic BVALID,
	input wire logic [1:0] BRESP,
	// pins
	input wire logic [7:0] P4_IN,
	input wire logic [7:0] P4_OE,
	input wire logic [7:0] P5_OE,
	input wire logic [7:0] P5_PU,
	input wire logic [7:0] P6_OE,
	input wire logic [7:0] P6_PU,
	input wire logic [2:0] P7_OE,
	input wire logic [2:0] P7_PU,
	input wire logic [7:0] P12_OE,
	input wire logic [7:0] P12_PU,
	input wire logic [1:0] P13_OE,
	input wire logic [1:0] P13_PU,
	// bus controller and flag
	input wire logic BUS_WAIT_N,
	input wire logic BUS_EXP_ON,
	input wire logic KEY_FLAG
);
	// ********
	// checks
	// ********
	default clocking dc @(posedge REF_CLK);
	endclocking
	default disable iff (!RESETN);
	// pins must come out of reset undriven and unpulled
	chk_reset_all_in: assert property (!$past(RESETN) |->
		(P4_OE | P5_OE | P6_OE | P12_OE | P5_PU | P6_PU | P12_PU) == 8'h00
		&& {P7_OE, P13_OE, P7_PU, P13_PU} == 10'h000)
		else $error("pins active after reset");
	chk_p4_byte_dir: assert property (P4_OE == 8'h00 || P4_OE == 8'hFF)
		else $error("port 4 direction split");
	chk_pu_input_only: assert property (
		((P5_PU & P5_OE) | (P6_PU & P6_OE) | (P12_PU & P12_OE)) == 8'h00
		&& (P7_PU & P7_OE) == 3'h0 && (P13_PU & P13_OE) == 2'h0)
		else $error("pull-up on driven pin");
	chk_p5_pu_group: assert property (!BUS_EXP_ON |-> P5_PU == 8'h00 || P5_PU == ~P5_OE)
		else $error("port 5 pull-up not grouped");
	chk_p6_pu_split: assert property (P6_PU[3:0] == (P6_LOW_PULLUP & ~P6_OE[3:0])
		&& (BUS_EXP_ON || P6_PU[7:4] == 4'h0 || P6_PU[7:4] == ~P6_OE[7:4]))
		else $error("port 6 pull-up split wrong");
	chk_small_pu_grp: assert property ((P7_PU == 3'h0 || P7_PU == ~P7_OE)
		&& (P12_PU == 8'h00 || P12_PU == ~P12_OE) && (P13_PU == 2'h0 || P13_PU == ~P13_OE))
		else $error("pull-up group broken");
	// the flag rises only a few cycles after some pin fell
	chk_flag_cause: assert property ($rose(KEY_FLAG) |->
		|(($past(P4_IN, 5) & ~$past(P4_IN, 4)) | ($past(P4_IN, 4) & ~$past(P4_IN, 3))
		| ($past(P4_IN, 3) & ~$past(P4_IN, 2))))
		else $error("flag set without falling edge");
	chk_flag_clear: assert property ($fell(KEY_FLAG) |-> $rose(BVALID))
		else $error("flag dropped without a write");
	chk_wait_plain: assert property (!BUS_EXP_ON |-> BUS_WAIT_N)
		else $error("wait asserted outside expansion");
	chk_read_turn: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read answer late");
	// main scenarios reached
	cover property ($rose(KEY_FLAG));
	cover property (BUS_EXP_ON && !BUS_WAIT_N);
	cover property (BVALID && BRESP == RESP_SLVERR);
endmodule // gpx_gpio_monitor

bind gpx_gpio gpx_gpio_monitor #(.P6_LOW_PULLUP(P6_LOW_PULLUP)) gpx_gpio_monitor_inst (.*);

// file: gpx_gpio_tb.sv
module gpx_gpio_tb;
	import gpx_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// ********
	// wiring
	// ********
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
		logic [1:0] r;
	} gpx_row_type;
	// register write, read-back value, response
	localparam gpx_row_type rows [11] = '{
		'{OFF_DIR5, 8'h0F, 8'h0F, RESP_OKAY},
		'{OFF_DIR6, 8'hA5, 8'hA5, RESP_OKAY},
		'{OFF_DIR7, 8'h00, 8'hF8, RESP_OKAY},
		'{OFF_DIR12, 8'h3C, 8'h3C, RESP_OKAY},
		'{OFF_DIR13, 8'h02, 8'hFE, RESP_OKAY},
		'{OFF_PULLUP_OPTION_LOW_REG, 8'hFF, 8'hF0, RESP_OKAY},
		'{OFF_PULLUP_OPTION_HIGH_REG, 8'hFF, 8'h30, RESP_OKAY},
		'{OFF_MEMEXP, 8'hFF, 8'h37, RESP_OKAY},
		'{OFF_KRMODE, 8'hFE, 8'h00, RESP_OKAY},
		'{OFF_LATCH12, 8'h5A, 8'h42, RESP_OKAY},
		'{8'h3C, 8'h55, 8'h00, RESP_SLVERR}
	};
	localparam logic [7:0] dir_regs [5] = '{OFF_DIR5, OFF_DIR6, OFF_DIR7, OFF_DIR12, OFF_DIR13};
	logic REF_CLK = 1'h0, RESETN = 1'h0, CE = 1'h1, BREADY = 1'h1, RREADY = 1'h1;
	logic AWVALID = 1'h0, WVALID = 1'h0, ARVALID = 1'h0;
	logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
	logic [31:0] WDATA = 32'h0, RDATA;
	logic [3:0] WSTRB = 4'hF;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, BUS_WAIT_N, BUS_EXP_ON, KEY_FLAG;
	logic [1:0] BRESP, RRESP;
	logic [7:0] P4_IN, P4_OUT, P4_OE, P4_PU, P5_IN, P5_OUT, P5_OE, P5_PU;
	logic [7:0] P6_IN, P6_OUT, P6_OE, P6_PU, P12_IN, P12_OUT, P12_OE, P12_PU;
	logic [2:0] P7_IN, P7_OUT, P7_OE, P7_PU;
	logic [1:0] P13_IN, P13_OUT, P13_OE, P13_PU;
	logic [7:0] BUS_AD_OUT = 8'h00, BUS_ADDR_HI = 8'h00, BUS_AD_IN;
	logic BUS_AD_OE = 1'h0, BUS_RD_N = 1'h1, BUS_WR_N = 1'h1, BUS_ASTB = 1'h0;
	logic [7:0] x4 = 8'hFF, x5 = 8'hC3, x6 = 8'h0F, x12 = 8'hC3;
	logic [2:0] x7 = 3'h5;
	logic [1:0] x13 = 2'h0;
	logic [7:0] xen = 8'hFF;
	int miscompares = 0, checks = 0, cyc = 0;
	gpx_gpio gpx_gpio_inst (.*);
	gpx_pin_model #(.W(8)) m4 (.clk(REF_CLK), .oe(P4_OE), .out(P4_OUT), .pu(P4_PU), .ext(x4),
		.en(xen), .pin(P4_IN));
	gpx_pin_model #(.W(8)) m5 (.clk(REF_CLK), .oe(P5_OE), .out(P5_OUT), .pu(P5_PU), .ext(x5),
		.en(xen), .pin(P5_IN));
	gpx_pin_model #(.W(8)) m6 (.clk(REF_CLK), .oe(P6_OE), .out(P6_OUT), .pu(P6_PU), .ext(x6),
		.en(xen), .pin(P6_IN));
	gpx_pin_model #(.W(3)) m7 (.clk(REF_CLK), .oe(P7_OE), .out(P7_OUT), .pu(P7_PU), .ext(x7),
		.en(xen[2:0]), .pin(P7_IN));
	gpx_pin_model #(.W(8)) m12 (.clk(REF_CLK), .oe(P12_OE), .out(P12_OUT), .pu(P12_PU),
		.ext(x12), .en(xen), .pin(P12_IN));
	gpx_pin_model #(.W(2)) m13 (.clk(REF_CLK), .oe(P13_OE), .out(P13_OUT), .pu(P13_PU),
		.ext(x13), .en(xen[1:0]), .pin(P13_IN));
	// ********
	// tasks
	// ********
	task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw, w;
		aw = 1'h0;
		w = 1'h0;
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'h1;
		WVALID <= 1'h1;
		while (!(aw && w)) begin
			@(posedge REF_CLK);
			if (!aw && AWREADY) begin
				aw = 1'h1;
				AWVALID <= 1'h0;
			end
			if (!w && WREADY) begin
				w = 1'h1;
				WVALID <= 1'h0;
			end
		end
		do @(posedge REF_CLK); while (!BVALID);
		cmp({30'h0, BRESP}, {30'h0, r}, "write response");
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r, string m);
		ARADDR <= a;
		ARVALID <= 1'h1;
		do @(posedge REF_CLK); while (!ARREADY);
		ARVALID <= 1'h0;
		do @(posedge REF_CLK); while (!RVALID);
		cmp(RDATA, e, m);
		cmp({30'h0, RRESP}, {30'h0, r}, m);
	endtask
	task automatic pc(input logic [7:0] oe, pu, eo, ep, input string m);
		cmp({oe, pu}, {eo, ep}, m);
	endtask
	// 20 MHz clock
	always begin
		#25 REF_CLK = ~REF_CLK;
	end
	// hang guard, far beyond the few hundred cycles the run needs
	always @(posedge REF_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			print_verdict();
		end
	end
	// ********
	// sequence
	// ********
	initial begin
		repeat (12) @(posedge REF_CLK);
		RESETN <= 1'h1;
		@(posedge REF_CLK);
		pc(P4_OE | P5_OE | P6_OE | P12_OE, P4_PU | P5_PU | P6_PU | P12_PU, 0, 0, "rst");
		foreach (dir_regs[i]) rd(dir_regs[i], 32'h0000_00FF, RESP_OKAY, "dir reset");
		rd(OFF_PULLUP_OPTION_LOW_REG, 32'h0, RESP_OKAY, "low pull-up reset");
		rd(OFF_PULLUP_OPTION_HIGH_REG, 32'h0, RESP_OKAY, "high pull-up reset");
		rd(OFF_MEMEXP, 32'h0000_0010, RESP_OKAY, "mode reset");
		foreach (rows[i]) begin
			wr(rows[i].a, {24'h0, rows[i].d}, rows[i].r);
			rd(rows[i].a, {24'h0, rows[i].e}, rows[i].r, "row read-back");
		end
		pc(P4_OE, P4_PU, 8'h00, 8'hFF, "p4 pins");
		pc(P5_OE, P5_PU, 8'hF0, 8'h0F, "p5 pins");
		pc(P6_OE, P6_PU, 8'h5A, 8'hA0, "p6 pins");
		pc({5'h0, P7_OE}, {5'h0, P7_PU}, 8'h07, 8'h00, "p7 pins");
		pc(P12_OE, P12_PU, 8'hC3, 8'h3C, "p12 pins");
		pc({6'h0, P13_OE}, {6'h0, P13_PU}, 8'h01, 8'h02, "p13 pins");
		// external drivers let go: only the pull-ups hold the port 12 inputs high
		xen <= 8'h00;
		rd(OFF_LATCH12, 32'h0000_007E, RESP_OKAY, "p12 pulled");
		xen <= 8'hFF;
		wr(OFF_PULLUP_OPTION_LOW_REG, 32'h0000_0040, RESP_OKAY);
		pc(P6_PU, P5_PU | P4_PU, 8'hA0, 8'h00, "upper p6 enable");
		wr(OFF_LATCH5, 32'h0000_003C, RESP_OKAY);
		rd(OFF_LATCH5, 32'h0000_0033, RESP_OKAY, "p5 mixed read");
		wr(OFF_DIR5, 32'h0, RESP_OKAY);
		rd(OFF_LATCH5, 32'h0000_003C, RESP_OKAY, "p5 latch kept");
		WSTRB <= 4'hE;
		wr(OFF_DIR12, 32'h0, RESP_OKAY);
		WSTRB <= 4'hF;
		rd(OFF_DIR12, 32'h0000_003C, RESP_OKAY, "lane off");
		wr(OFF_LATCH13, 32'h0, RESP_OKAY);
		cmp({30'h0, P13_OUT[0], P13_OE[0]}, 32'h0000_0001, "p13 parked low");
		// every port 4 pin falls once; the flag holds until cleared
		for (int i = 0; i < 8; i++) begin
			x4 <= ~(8'h01 << i);
			repeat (4) @(posedge REF_CLK);
			cmp({31'h0, KEY_FLAG}, 32'h1, "flag set");
			x4 <= 8'hFF;
			rd(OFF_KRFLAG, 32'h1, RESP_OKAY, "flag held");
			wr(OFF_KRFLAG, 32'h1, RESP_OKAY);
			cmp({31'h0, KEY_FLAG}, 32'h0, "flag cleared");
		end
		// enable low freezes the detector, so a fall undone before enable returns is never seen
		CE <= 1'h0;
		x4 <= 8'h00;
		repeat (6) @(posedge REF_CLK);
		cmp({31'h0, KEY_FLAG}, 32'h0, "frozen");
		x4 <= 8'hFF;
		@(posedge REF_CLK);
		CE <= 1'h1;
		wr(OFF_KRMODE, 32'h1, RESP_OKAY);
		x4 <= 8'h00;
		repeat (6) @(posedge REF_CLK);
		cmp({31'h0, KEY_FLAG}, 32'h0, "detect off");
		wr(OFF_PULLUP_OPTION_LOW_REG, 32'h0000_00F0, RESP_OKAY);
		wr(OFF_LATCH4, 32'h0000_0096, RESP_OKAY);
		wr(OFF_MEMEXP, 32'h1, RESP_OKAY);
		pc(P4_OE, P4_PU, 8'hFF, 8'h00, "p4 output");
		rd(OFF_LATCH4, 32'h0000_0096, RESP_OKAY, "p4 latch read");
		wr(OFF_DIR5, 32'h0000_00FF, RESP_OKAY);
		BUS_AD_OE <= 1'h1;
		BUS_AD_OUT <= 8'h5C;
		BUS_ADDR_HI <= 8'hA7;
		BUS_RD_N <= 1'h0;
		BUS_ASTB <= 1'h1;
		wr(OFF_MEMEXP, 32'h0000_0005, RESP_OKAY);
		pc(P4_OE, P4_PU, 8'hFF, 8'h00, "exp data bus");
		pc(P5_OE, P5_PU, 8'h3F, 8'hC0, "exp address");
		pc(P6_OE, P6_PU, 8'hFA, 8'h00, "exp control");
		cmp({BUS_EXP_ON, BUS_WAIT_N, P4_OUT, P5_OUT[5:0], P6_OUT[7:4]},
			{1'h1, 1'h1, 8'h5C, 6'h27, 4'hA}, "exp values");
		BUS_WR_N <= 1'h0;
		wr(OFF_MEMEXP, 32'h0000_0025, RESP_OKAY);
		cmp({30'h0, BUS_WAIT_N, P6_OUT[5]}, 32'h0, "wait input");
		BUS_AD_OE <= 1'h0;
		// a second reset in mid-run
		RESETN <= 1'h0;
		repeat (2) @(posedge REF_CLK);
		RESETN <= 1'h1;
		@(posedge REF_CLK);
		pc(P4_OE | P5_OE | P6_OE | P12_OE, {7'h0, KEY_FLAG}, 0, 0, "second reset");
		print_verdict();
	end
endmodule // gpx_gpio_tb
